// *** hdl/ams_pkg.sv ***
package ams_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_IRQ_STS = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h10;
  localparam logic [7:0] OFS_OFFSET  = 8'h14;
  localparam logic [7:0] OFS_LIN     = 8'h18;

  // Configuration field positions
  localparam int CFG_MUX_LSB = 0;
  localparam int CFG_MUX_W   = 4;
  localparam int CFG_ACQ_LSB = 4;
  localparam int CFG_ACQ_W   = 2;
  localparam int CFG_SE_BIT  = 6;
  localparam int CFG_SYNC_BIT = 8;
  localparam int CFG_CMD_LSB = 9;
  localparam int CFG_CMD_W   = 3;

  // Command codes
  localparam logic [2:0] CMD_STANDBY = 3'h0;
  localparam logic [2:0] CMD_FULLCAL = 3'h1;
  localparam logic [2:0] CMD_AUTOZERO = 3'h2;
  localparam logic [2:0] CMD_RESET   = 3'h3;
  localparam logic [2:0] CMD_START   = 3'h4;

  // Acquisition lengths in master cycles
  localparam logic [6:0] ACQ_LEN0 = 7'h09;
  localparam logic [6:0] ACQ_LEN1 = 7'h0f;
  localparam logic [6:0] ACQ_LEN2 = 7'h2f;
  localparam logic [6:0] ACQ_LEN3 = 7'h4f;

  // Default timing counts
  localparam int WAKE_CYCLES = 16;
  localparam int CONV_CYCLES = 44;
  localparam int CAL_REPEAT  = 8;
  localparam int CAL_CAPS    = 12;
  localparam int AZ_CYCLES   = 32;

  // Interrupt bits
  localparam int IRQ_CONV_DONE = 0;
  localparam int IRQ_CAL_DONE  = 1;
  localparam int IRQ_WAKE      = 2;
  localparam int IRQ_W         = 3;

  // Reset values
  localparam logic [12:0] CONFIG_RST = 13'h0100;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_WAKE    = 3'b001,
    ST_IDLE    = 3'b011,
    ST_ACQ     = 3'b010,
    ST_CONV    = 3'b110,
    ST_CAL_OFS = 3'b111,
    ST_CAL_LIN = 3'b101,
    ST_AZ      = 3'b100
  } ams_state_e;

endpackage

// *** hdl/ams_sequencer.sv ***
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Behaviour
// RL1: Differential mode pairs 0-1,2-3,4-5,6-7 either order
// RL2: Single-ended: any channel positive, negative to common
// RL3: Standby command enters standby, status output low
// RL4: Non-standby command raises standby status immediately
// RL5: Ready falls only after standby actually exited
// RL6: Power-up state is standby, status low
// RL7: Sync bit set: sync pin input, rising starts
// RL8: Power-up mode is synchronous, sync pin input
// RL9: Sync bit clear: sync output high during conversion
// RL10: Async acquisition counts 9/15/47/79 master cycles
// RL11: Async acquisition on channel change/ready fall; read
// RL12: Sync mode ignores acquisition field, sync edge ends
// RL13: Sync acquisition starts at channel write or ready
// RL14: Full-calibration command starts calibration cycle
// RL15: Calibration averages eight offset measurements, stores
// RL16: Each capacitor compared eight times, errors averaged
// RL17: Command decode 000..100 standby/cal/zero/reset/start
// RL18: Ready high during event, low when done
// RL19: Acquisition code ascending 00=9 ... 11=79
module ams_sequencer #(
  parameter int WAKE_CYCLES = ams_pkg::WAKE_CYCLES,
  parameter int CONV_CYCLES = ams_pkg::CONV_CYCLES,
  parameter int AZ_CYCLES   = ams_pkg::AZ_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Result read strobe, offset sample and capacitor error from the analog side
  input  wire logic        RESULT_READ,
  input  wire logic [12:0] OFFSET_SAMPLE,
  input  wire logic [12:0] CAP_ERROR,
  // Sync pin
  input  wire logic        SYNC_IN,
  output logic             SYNC_OUT,
  output logic             SYNC_OE,
  // Multiplexer routing
  output logic      [7:0]  MUX_POS_SEL,
  output logic      [7:0]  MUX_NEG_SEL,
  output logic             MUX_NEG_COMMON,
  // Status
  output logic             READY_N,
  output logic             STANDBY_STATUS_N,
  output logic             IRQ
);

  typedef struct packed {
    logic [12:0]       cfg;
    ams_pkg::ams_state_e st;
    logic [6:0]        cnt;
    logic [3:0]        rep;
    logic [3:0]        cap;
    logic [15:0]       acc;
    logic [12:0]       ofs_coef;
    logic [12:0]       lin_coef;
    logic              new_ch;
    logic              sync_d;
    logic [2:0]        irq_sts;
    logic [2:0]        irq_en;
    logic              ack;
    logic [31:0]       dat;
    logic              ready_n;
    logic              stby_n;
    logic              sync_o;
    logic              sync_oe;
    logic [7:0]        mpos;
    logic [7:0]        mneg;
    logic              mcom;
    logic              irq;
  } ams_state_s;

  ams_state_s s_reg;
  ams_state_s s_next;

  logic [6:0]  acq_len;
  logic        wr_cmd;
  logic        rd_cmd;
  logic [2:0]  cmd;
  logic [2:0]  ev;
  logic        sync_rise;
  logic [12:0] wcfg;

  ////////////////////////////////////////////////////////////////////////
  // Acquisition length decode
  always_comb begin
    unique case (s_reg.cfg[ams_pkg::CFG_ACQ_LSB +: ams_pkg::CFG_ACQ_W])
      2'h0: acq_len = ams_pkg::ACQ_LEN0; // RL19 RL10
      2'h1: acq_len = ams_pkg::ACQ_LEN1;
      2'h2: acq_len = ams_pkg::ACQ_LEN2;
      2'h3: acq_len = ams_pkg::ACQ_LEN3;
    endcase
  end

  assign wcfg      = WB_DAT_I[12:0];
  assign wr_cmd    = WB_CYC_I && WB_STB_I && WB_WE_I && !s_reg.ack && WB_SEL_I[0]
                     && (WB_ADR_I == ams_pkg::OFS_CONFIG);
  assign rd_cmd    = RESULT_READ;
  assign cmd       = wcfg[ams_pkg::CFG_CMD_LSB +: ams_pkg::CFG_CMD_W];
  assign sync_rise = SYNC_IN && !s_reg.sync_d;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic sync_mode;
    logic [2:0] ch;
    s_next    = s_reg;
    ev        = 3'h0;
    sync_mode = s_reg.cfg[ams_pkg::CFG_SYNC_BIT];
    ch        = s_reg.cfg[2:0];
    s_next.sync_d = SYNC_IN;
    s_next.ack    = WB_CYC_I && WB_STB_I && !s_reg.ack;

    // Sequencer
    unique case (s_reg.st)
      ams_pkg::ST_STANDBY: begin
        s_next.ready_n = 1'b1;
      end
      ams_pkg::ST_WAKE: begin
        if (s_reg.cnt == 7'(WAKE_CYCLES - 1)) begin
          s_next.st      = ams_pkg::ST_IDLE;
          s_next.ready_n = 1'b0; // RL5
          s_next.cnt     = 7'h00;
          ev[ams_pkg::IRQ_WAKE] = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 7'h01;
        end
      end
      ams_pkg::ST_IDLE: begin
        // Acquisition starts on a result read here; a channel change starts it at the command write
        if (s_reg.cfg[ams_pkg::CFG_CMD_LSB +: ams_pkg::CFG_CMD_W] == ams_pkg::CMD_START) begin
          if (sync_mode && (sync_rise || rd_cmd)) begin
            s_next.ready_n = 1'b1; // RL12 RL13
            s_next.st      = sync_rise ? ams_pkg::ST_CONV : ams_pkg::ST_ACQ;
            s_next.cnt     = 7'h00;
          end else if (!sync_mode && rd_cmd) begin
            s_next.ready_n = 1'b1; // RL11
            s_next.st      = ams_pkg::ST_ACQ;
            s_next.cnt     = 7'h00;
          end
        end
      end
      ams_pkg::ST_ACQ: begin
        if (sync_mode) begin
          if (sync_rise) begin
            s_next.st  = ams_pkg::ST_CONV; // RL7 RL12
            s_next.cnt = 7'h00;
          end
        end else if (s_reg.cnt == acq_len - 7'h01) begin
          s_next.st     = ams_pkg::ST_CONV; // RL10
          s_next.cnt    = 7'h00;
          s_next.sync_o = 1'b1; // RL9
        end else begin
          s_next.cnt = s_reg.cnt + 7'h01;
        end
      end
      ams_pkg::ST_CONV: begin
        if (s_reg.cnt == 7'(CONV_CYCLES - 1)) begin
          s_next.st      = ams_pkg::ST_IDLE;
          s_next.ready_n = 1'b0; // RL18
          s_next.sync_o  = 1'b0; // RL9
          s_next.new_ch  = 1'b0;
          s_next.cnt     = 7'h00;
          ev[ams_pkg::IRQ_CONV_DONE] = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 7'h01;
        end
      end
      ams_pkg::ST_CAL_OFS: begin
        s_next.acc = s_reg.acc + {3'h0, OFFSET_SAMPLE}; // RL15
        if (s_reg.rep == 4'(ams_pkg::CAL_REPEAT - 1)) begin
          s_next.ofs_coef = s_next.acc[15:3]; // RL15
          s_next.acc      = 16'h0000;
          s_next.rep      = 4'h0;
          s_next.cap      = 4'h0;
          s_next.st       = ams_pkg::ST_CAL_LIN;
        end else begin
          s_next.rep = s_reg.rep + 4'h1;
        end
      end
      ams_pkg::ST_CAL_LIN: begin
        s_next.acc = s_reg.acc + {3'h0, CAP_ERROR}; // RL16
        if (s_reg.rep == 4'(ams_pkg::CAL_REPEAT - 1)) begin
          s_next.lin_coef = s_next.acc[15:3]; // RL16
          s_next.acc      = 16'h0000;
          s_next.rep      = 4'h0;
          if (s_reg.cap == 4'(ams_pkg::CAL_CAPS - 1)) begin
            s_next.st      = ams_pkg::ST_IDLE;
            s_next.ready_n = 1'b0; // RL14 RL18
            ev[ams_pkg::IRQ_CAL_DONE] = 1'b1;
          end else begin
            s_next.cap = s_reg.cap + 4'h1;
          end
        end else begin
          s_next.rep = s_reg.rep + 4'h1;
        end
      end
      ams_pkg::ST_AZ: begin
        if (s_reg.cnt == 7'(AZ_CYCLES - 1)) begin
          s_next.ofs_coef = OFFSET_SAMPLE;
          s_next.st       = ams_pkg::ST_IDLE;
          s_next.ready_n  = 1'b0;
          s_next.cnt      = 7'h00;
          ev[ams_pkg::IRQ_CAL_DONE] = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 7'h01;
        end
      end
    endcase

    // Command write
    if (wr_cmd) begin
      s_next.cfg    = wcfg;
      s_next.new_ch = (wcfg[3:0] != s_reg.cfg[3:0]); // RL13
      s_next.cnt    = 7'h00;
      s_next.rep    = 4'h0;
      s_next.acc    = 16'h0000;
      s_next.sync_o = 1'b0;
      unique case (cmd) // RL17
        ams_pkg::CMD_STANDBY: begin
          s_next.st      = ams_pkg::ST_STANDBY; // RL3
          s_next.stby_n  = 1'b0;
          s_next.ready_n = 1'b1;
        end
        default: begin
          s_next.stby_n = 1'b1; // RL4
          if (s_reg.st == ams_pkg::ST_STANDBY) begin
            s_next.st      = ams_pkg::ST_WAKE; // RL5
            s_next.ready_n = 1'b1;
          end else if (cmd == ams_pkg::CMD_FULLCAL) begin
            s_next.st      = ams_pkg::ST_CAL_OFS; // RL14
            s_next.ready_n = 1'b1;
          end else if (cmd == ams_pkg::CMD_AUTOZERO) begin
            s_next.st      = ams_pkg::ST_AZ;
            s_next.ready_n = 1'b1;
          end else if (cmd == ams_pkg::CMD_START && wcfg[3:0] != s_reg.cfg[3:0]) begin
            s_next.st      = ams_pkg::ST_ACQ; // RL13
            s_next.ready_n = 1'b1;
          end else begin
            s_next.st      = ams_pkg::ST_IDLE;
            s_next.ready_n = 1'b0;
          end
        end
      endcase
    end

    // Sync pin direction follows the mode bit
    s_next.sync_oe = !s_next.cfg[ams_pkg::CFG_SYNC_BIT]; // RL7 RL9
    if (!s_next.sync_oe) s_next.sync_o = 1'b0;

    // Multiplexer routing
    ch = s_next.cfg[2:0];
    s_next.mpos = 8'h01 << ch;
    if (s_next.cfg[ams_pkg::CFG_SE_BIT] || s_next.cfg[3]) begin
      s_next.mneg = 8'h00; // RL2
      s_next.mcom = 1'b1;
    end else begin
      s_next.mneg = 8'h01 << {ch[2:1], !ch[0]}; // RL1
      s_next.mcom = 1'b0;
    end

    // Interrupt status: set wins over clear
    if (WB_CYC_I && WB_STB_I && WB_WE_I && !s_reg.ack && WB_ADR_I == ams_pkg::OFS_IRQ_CLR)
      s_next.irq_sts = s_reg.irq_sts & ~WB_DAT_I[2:0];
    if (WB_CYC_I && WB_STB_I && WB_WE_I && !s_reg.ack && WB_ADR_I == ams_pkg::OFS_IRQ_EN)
      s_next.irq_en = WB_DAT_I[2:0];
    s_next.irq_sts = s_next.irq_sts | ev;
    s_next.irq     = |(s_next.irq_sts & s_next.irq_en);

    // Read data
    unique case (WB_ADR_I)
      ams_pkg::OFS_CONFIG:  s_next.dat = {19'h0, s_reg.cfg};
      ams_pkg::OFS_STATUS:  s_next.dat = {26'h0, s_reg.sync_o, s_reg.stby_n, s_reg.ready_n, s_reg.st};
      ams_pkg::OFS_IRQ_STS: s_next.dat = {29'h0, s_reg.irq_sts};
      ams_pkg::OFS_IRQ_EN:  s_next.dat = {29'h0, s_reg.irq_en};
      ams_pkg::OFS_OFFSET:  s_next.dat = {19'h0, s_reg.ofs_coef};
      ams_pkg::OFS_LIN:     s_next.dat = {19'h0, s_reg.lin_coef};
      default:              s_next.dat = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_reg         <= '0;
      s_reg.cfg     <= ams_pkg::CONFIG_RST; // RL8
      s_reg.st      <= ams_pkg::ST_STANDBY; // RL6
      s_reg.ready_n <= 1'b1;
      s_reg.stby_n  <= 1'b0; // RL6
      s_reg.mpos    <= 8'h01;
      s_reg.mneg    <= 8'h02;
    end else begin
      s_reg <= s_next;
    end
  end

  assign WB_DAT_O         = s_reg.dat;
  assign WB_ACK_O         = s_reg.ack;
  assign SYNC_OUT         = s_reg.sync_o;
  assign SYNC_OE          = s_reg.sync_oe;
  assign MUX_POS_SEL      = s_reg.mpos;
  assign MUX_NEG_SEL      = s_reg.mneg;
  assign MUX_NEG_COMMON   = s_reg.mcom;
  assign READY_N          = s_reg.ready_n;
  assign STANDBY_STATUS_N = s_reg.stby_n;
  assign IRQ              = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_STBY_ENTER: assert property (@(posedge CLK) disable iff (!RESET_N) // RL3
    wr_cmd && cmd == ams_pkg::CMD_STANDBY |=> !STANDBY_STATUS_N && READY_N)
    else $error("standby not entered");
  AST_STBY_EXIT: assert property (@(posedge CLK) disable iff (!RESET_N) // RL4
    wr_cmd && cmd != ams_pkg::CMD_STANDBY |=> STANDBY_STATUS_N)
    else $error("standby status not raised");
  AST_WAKE_READY: assert property (@(posedge CLK) disable iff (!RESET_N) // RL5
    s_reg.st == ams_pkg::ST_WAKE && !wr_cmd |=> READY_N || s_reg.st == ams_pkg::ST_IDLE)
    else $error("ready low during wake");
  AST_STBY_READY: assert property (@(posedge CLK) disable iff (!RESET_N) // RL18
    !STANDBY_STATUS_N |-> READY_N)
    else $error("ready low in standby");
  AST_SE_NEG: assert property (@(posedge CLK) disable iff (!RESET_N) // RL2
    s_reg.cfg[ams_pkg::CFG_SE_BIT] |-> MUX_NEG_COMMON && MUX_NEG_SEL == 8'h00)
    else $error("single ended negative wrong");
  AST_DIFF_PAIR: assert property (@(posedge CLK) disable iff (!RESET_N) // RL1
    !MUX_NEG_COMMON |-> (MUX_NEG_SEL == {MUX_POS_SEL[6], MUX_POS_SEL[7], MUX_POS_SEL[4], MUX_POS_SEL[5],
                                        MUX_POS_SEL[2], MUX_POS_SEL[3], MUX_POS_SEL[0], MUX_POS_SEL[1]}))
    else $error("differential pair wrong");
  AST_SYNC_DIR: assert property (@(posedge CLK) disable iff (!RESET_N) // RL7
    s_reg.cfg[ams_pkg::CFG_SYNC_BIT] |-> !SYNC_OE && !SYNC_OUT)
    else $error("sync pin driven in sync mode");
  AST_SYNC_CONV: assert property (@(posedge CLK) disable iff (!RESET_N) // RL9
    SYNC_OUT |-> s_reg.st == ams_pkg::ST_CONV)
    else $error("sync high outside conversion");
  AST_ACQ9: assert property (@(posedge CLK) disable iff (!RESET_N) // RL10
    s_reg.st == ams_pkg::ST_ACQ && !s_reg.cfg[ams_pkg::CFG_SYNC_BIT] && s_reg.cnt == 7'h00 && acq_len == 7'h09
    && !wr_cmd |-> ##8 (s_reg.st == ams_pkg::ST_ACQ || $past(wr_cmd)))
    else $error("acquisition ended early");
  AST_CAL_READY: assert property (@(posedge CLK) disable iff (!RESET_N) // RL14
    wr_cmd && cmd == ams_pkg::CMD_FULLCAL && STANDBY_STATUS_N |=> READY_N)
    else $error("ready not raised by calibration");
  AST_NEW_CH_ACQ: assert property (@(posedge CLK) disable iff (!RESET_N) // RL13
    wr_cmd && cmd == ams_pkg::CMD_START && STANDBY_STATUS_N && wcfg[3:0] != s_reg.cfg[3:0]
    |=> s_reg.st == ams_pkg::ST_ACQ && s_reg.new_ch && READY_N)
    else $error("new channel did not start acquisition");
  AST_READ_START: assert property (@(posedge CLK) disable iff (!RESET_N) // RL11
    s_reg.st == ams_pkg::ST_IDLE && !s_reg.cfg[ams_pkg::CFG_SYNC_BIT] && rd_cmd && !wr_cmd
    && s_reg.cfg[ams_pkg::CFG_CMD_LSB +: ams_pkg::CFG_CMD_W] == ams_pkg::CMD_START
    |=> s_reg.st == ams_pkg::ST_ACQ && READY_N)
    else $error("read did not start acquisition");
  AST_SYNC_HOLD_ACQ: assert property (@(posedge CLK) disable iff (!RESET_N) // RL12
    s_reg.st == ams_pkg::ST_ACQ && s_reg.cfg[ams_pkg::CFG_SYNC_BIT] && !sync_rise && !wr_cmd
    |=> s_reg.st == ams_pkg::ST_ACQ)
    else $error("sync acquisition ended without sync edge");
  AST_CONV_SYNC_HIGH: assert property (@(posedge CLK) disable iff (!RESET_N) // RL9
    s_reg.st == ams_pkg::ST_CONV && !s_reg.cfg[ams_pkg::CFG_SYNC_BIT] |-> SYNC_OUT)
    else $error("sync low during conversion");
  AST_CAL_OFS8: assert property (@(posedge CLK) disable iff (!RESET_N) // RL15
    s_reg.st == ams_pkg::ST_CAL_OFS && s_reg.rep == 4'h0 && !wr_cmd
    |-> ##8 (s_reg.st == ams_pkg::ST_CAL_LIN || $past(wr_cmd)))
    else $error("offset not measured eight times");
  COV_CAL: cover property (@(posedge CLK) s_reg.st == ams_pkg::ST_CAL_LIN ##1 s_reg.st == ams_pkg::ST_IDLE);
  COV_CONV: cover property (@(posedge CLK) s_reg.st == ams_pkg::ST_CONV ##1 s_reg.st == ams_pkg::ST_IDLE);
  COV_WAKE: cover property (@(posedge CLK) s_reg.st == ams_pkg::ST_WAKE ##1 s_reg.st == ams_pkg::ST_IDLE);
  COV_SYNC_CONV: cover property (@(posedge CLK)
    s_reg.st == ams_pkg::ST_ACQ && sync_rise ##1 s_reg.st == ams_pkg::ST_CONV);
  COV_NEW_CH: cover property (@(posedge CLK) s_reg.new_ch && s_reg.st == ams_pkg::ST_ACQ);

endmodule

// *** verif/ams_host_model.sv ***
`timescale 1ns/10ps
module ams_host_model (
  // Clock and trigger
  input  wire logic CLK,
  input  wire logic FIRE,
  // Sync pin level toward the sequencer
  output logic      SYNC_IN
);
  logic [1:0] hold_reg;

  initial begin
    SYNC_IN  = 1'b0;
    hold_reg = 2'h0;
  end

  // Three-cycle sync pulse, low while idle
  always @(posedge CLK) begin
    if (FIRE) begin
      hold_reg <= 2'h3;
    end else if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
    SYNC_IN <= FIRE || (hold_reg > 2'h1);
  end
endmodule

// *** verif/adc_mode_sequencer_tb.sv ***
`timescale 1ns/10ps
module adc_mode_sequencer_tb;
  localparam int WK = 4;
  localparam int CV = 6;
  localparam int AZ = 5;
  logic        clk, rst_n, cyc, stb, we, rd, fire, sin, so, soe, mc, rdy_n, sn, irq, ack;
  logic [7:0]  adr, mp, mn;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, r;
  logic [12:0] ofs, cap;
  logic [31:0] exp_q[$];
  int          mismatches, check_count, cycles, n, seed;
  int          lens[4] = '{9, 15, 47, 79};

  ams_sequencer #(.WAKE_CYCLES(WK), .CONV_CYCLES(CV), .AZ_CYCLES(AZ)) u_dut (
    .CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .RESULT_READ(rd),
    .OFFSET_SAMPLE(ofs), .CAP_ERROR(cap), .SYNC_IN(sin), .SYNC_OUT(so), .SYNC_OE(soe),
    .MUX_POS_SEL(mp), .MUX_NEG_SEL(mn), .MUX_NEG_COMMON(mc), .READY_N(rdy_n),
    .STANDBY_STATUS_N(sn), .IRQ(irq));

  ams_host_model u_host (.CLK(clk), .FIRE(fire), .SYNC_IN(sin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_near(input string nm, input int e, input int g, input int tol);
    check_count++;
    if (g < e - tol || g > e + tol) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] mkcfg(input logic [3:0] mx, input logic [1:0] aq, input logic se,
                                        input logic sy, input logic [2:0] c);
    return {20'h0, c, sy, 1'b0, se, aq, mx};
  endfunction

  // Classic cycle; read expectations go to the queue
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    if (!w) exp_q.push_back(e);
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) mismatches++;
  endtask

  task automatic cnt(input int s, input logic v, output int m);
    m = 0;
    while (((s == 0) ? rdy_n : so) === v && m < 3000) begin
      @(negedge clk);
      m++;
    end
  endtask

  task automatic fire_sync;
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic pulse_read;
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Read data taken at the edge where ack is sampled high
  always @(posedge clk) begin
    if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0 && exp_q.size() > 0) check_val("read data", exp_q.pop_front(), rdat);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
    rd = 1'b0; fire = 1'b0; ofs = 13'h0; cap = 13'h0; seed = 87757;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check_val("standby", 0, sn);
    check_val("ready", 1, rdy_n);
    check_val("sync oe", 0, soe);
    check_val("mux pos", 8'h01, mp);
    check_val("mux neg", 8'h02, mn);
    wb(1'b0, 8'h1c, 0, 0);
    wb(1'b1, ams_pkg::OFS_IRQ_EN, 7, 0);
    wb(1'b0, ams_pkg::OFS_IRQ_EN, 0, 7);
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, ams_pkg::OFS_CONFIG, mkcfg(0, 0, 0, 1, ams_pkg::CMD_STANDBY), 0);
      @(negedge clk);
      check_val("standby", 0, sn);
      check_val("ready", 1, rdy_n);
      wb(1'b1, ams_pkg::OFS_CONFIG, mkcfg(0, 0, 0, 1, ams_pkg::CMD_RESET), 0);
      @(negedge clk);
      check_val("standby", 1, sn);
      cnt(0, 1'b1, n);
      check_near("wake", WK, n, 2);
    end
    check_val("irq", 1, irq);
    // Asynchronous conversions over every acquisition code
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, ams_pkg::OFS_CONFIG, mkcfg(0, k[1:0], 0, 0, ams_pkg::CMD_START), 0);
      cnt(0, 1'b1, n);
      check_val("sync oe", 1, soe);
      pulse_read;
      check_val("ready", 1, rdy_n);
      cnt(1, 1'b0, n);
      check_near("acquisition", lens[k], n, 2);
      cnt(1, 1'b1, n);
      check_near("conversion", CV, n, 2);
      check_val("ready", 0, rdy_n);
    end
    // Synchronous: short code must not end acquisition
    wb(1'b1, ams_pkg::OFS_CONFIG, mkcfg(0, 0, 0, 1, ams_pkg::CMD_START), 0);
    cnt(0, 1'b1, n);
    check_val("sync oe", 0, soe);
    pulse_read;
    check_val("ready", 1, rdy_n);
    repeat (30) @(negedge clk);
    check_val("ready", 1, rdy_n);
    fire_sync;
    cnt(0, 1'b1, n);
    check_near("sync conversion", CV + 2, n, 3);
    // Synchronous start with a new channel
    wb(1'b1, ams_pkg::OFS_CONFIG, mkcfg(4'h5, 0, 0, 1, ams_pkg::CMD_START), 0);
    @(negedge clk);
    check_val("ready", 1, rdy_n);
    check_val("mux pos", 8'h20, mp);
    check_val("mux neg", 8'h10, mn);
    fire_sync;
    cnt(0, 1'b1, n);
    check_near("sync conversion", CV + 2, n, 3);
    // Calibration with constant samples
    wb(1'b1, ams_pkg::OFS_IRQ_CLR, 7, 0);
    r = $random(seed);
    @(posedge clk);
    ofs <= {1'b0, r[11:0]};
    cap <= r[28:16];
    wb(1'b1, ams_pkg::OFS_CONFIG, mkcfg(0, 0, 0, 1, ams_pkg::CMD_FULLCAL), 0);
    @(negedge clk);
    check_val("ready", 1, rdy_n);
    cnt(0, 1'b1, n);
    check_near("calibration", ams_pkg::CAL_REPEAT * (1 + ams_pkg::CAL_CAPS), n, 3);
    wb(1'b0, ams_pkg::OFS_OFFSET, 0, {20'h0, r[11:0]});
    wb(1'b0, ams_pkg::OFS_LIN, 0, {19'h0, r[28:16]});
    wb(1'b0, ams_pkg::OFS_IRQ_STS, 0, 2);
    check_val("irq", 1, irq);
    wb(1'b1, ams_pkg::OFS_IRQ_CLR, 7, 0);
    @(negedge clk);
    check_val("irq", 0, irq);
    wb(1'b1, ams_pkg::OFS_IRQ_EN, 0, 0);
    wb(1'b1, ams_pkg::OFS_CONFIG, mkcfg(0, 0, 0, 1, ams_pkg::CMD_AUTOZERO), 0);
    @(negedge clk);
    check_val("ready", 1, rdy_n);
    cnt(0, 1'b1, n);
    check_near("autozero", AZ, n, 2);
    wb(1'b0, ams_pkg::OFS_IRQ_STS, 0, 2);
    check_val("irq masked", 0, irq);
    wb(1'b0, ams_pkg::OFS_STATUS, 0, {26'h0, 3'b010, ams_pkg::ST_IDLE});
    // Reset in mid-run returns to the power-up state
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check_val("standby", 0, sn);
    check_val("ready", 1, rdy_n);
    check_val("sync oe", 0, soe);
    check_val("irq", 0, irq);
    wb(1'b0, ams_pkg::OFS_CONFIG, 0, ams_pkg::CONFIG_RST);
    // Routing in both multiplexer modes
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      wb(1'b1, ams_pkg::OFS_CONFIG, mkcfg({1'b0, r[2:0]}, 0, i[0], 1, ams_pkg::CMD_RESET), 0);
      @(negedge clk);
      check_val("mux pos", 8'h01 << r[2:0], mp);
      check_val("mux neg", i[0] ? 8'h00 : 8'h01 << (r[2:0] ^ 3'h1), mn);
      check_val("mux common", i[0], mc);
    end
    repeat (3) @(negedge clk);
    check_val("pending reads", 0, exp_q.size());
    tally_and_finish;
  end
endmodule
